// ---- inc/sar_adc_params.svh ----
`ifndef SAR_ADC_PARAMS_SVH
`define SAR_ADC_PARAMS_SVH

// Register byte addresses
`define ADDR_CTRL 16'hFE58
`define ADDR_MODE 16'hFE59
`define ADDR_LOW 16'hFE5A
`define ADDR_HIGH 16'hFE5B

// Reset value of every register, and unmapped read value
`define REG_RESET 8'h00

// Channel codes
`define CH_LAST_LOW 4'h6
`define CH_FIRST_HIGH 4'h8
`define CH_LAST_HIGH 4'hA
`define CH_REF 4'hE
`define CH_HIGH_OFFSET 4'h1
`define SEL_REF_BIT 10

// Conversion length in units of a third of an instruction cycle
`define UNITS_12 15'h0034
`define UNITS_8 15'h0020
`define UNITS_EXTRA 15'h0002

// System clock period and default instruction cycle, both in ns
`define CLK_NS 10
`define TCYC_NS_DEF 30

`endif

// ---- inc/sar_adc_pkg.sv ----
package sar_adc_pkg;

   // Control register layout
   typedef struct packed {
      logic [3:0] channel_field;
      logic control_fixed_zero;
      logic run_bit;
      logic completion_flag;
      logic completion_irq_enable;
   } ctrl_reg_t;

   // Mode register layout
   typedef struct packed {
      logic mode_fixed_zero_7;
      logic resolution_select;
      logic [3:0] mode_fixed_zero_5_2;
      logic time_code_mid;
      logic time_code_lsb;
   } mode_reg_t;

   // Low result register layout
   typedef struct packed {
      logic [3:0] result_nibble;
      logic [2:0] low_fixed_zero;
      logic time_code_msb;
   } low_reg_t;

   // Software port request
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } sw_req_t;

   // Sequencer state
   typedef enum logic [1:0] {
      st_idle = 2'b01,
      st_conv = 2'b10
   } conv_state_t;

endpackage

// ---- rtl/conv_timer.sv ----
`timescale 1ns/100ps
`include "sar_adc_params.svh"

// Counts a conversion length in units, each unit_clks clocks long
module conv_timer #(
   parameter int unit_clks = 1
) (
   input wire logic clock, // System clock
   input wire logic rstn, // Synchronous reset, active low
   input wire logic load, // Start counting units
   input wire logic abort, // Stop without completing
   input wire logic [14:0] units, // Length in units
   output logic busy, // Counting
   output logic done // Last cycle of the count
);

   localparam logic [15:0] PRE_TOP = 16'(unit_clks - 1);

   logic [14:0] units_q, units_d; // Units still to run
   logic [15:0] pre_q, pre_d; // Clocks left in this unit
   logic busy_q, busy_d; // Count in progress

   // Finishing on the final clock of the final unit
   assign done = busy_q && (pre_q == 16'h0000) && (units_q == 15'h0001);
   assign busy = busy_q;

   // Next count values
   always_comb
   begin
      units_d = units_q;
      pre_d = pre_q;
      busy_d = busy_q;
      if (load)
      begin
         // Load overrides any count already running
         units_d = units;
         pre_d = PRE_TOP;
         busy_d = 1'b1;
      end
      else if (abort || done)
      begin
         busy_d = 1'b0;
      end
      else if (busy_q)
      begin
         if (pre_q == 16'h0000)
         begin
            pre_d = PRE_TOP;
            units_d = units_q - 15'h0001;
         end
         else
         begin
            pre_d = pre_q - 16'h0001;
         end
      end
   end

   // Count registers
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         units_q <= 15'h0000;
         pre_q <= 16'h0000;
         busy_q <= 1'b0;
      end
      else
      begin
         units_q <= units_d;
         pre_q <= pre_d;
         busy_q <= busy_d;
      end
   end

endmodule

// ---- rtl/sar_adc_sequencer.sv ----
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
`include "sar_adc_params.svh"

module sar_adc_sequencer
   import sar_adc_pkg::*;
#(
   parameter int tcyc_ns = `TCYC_NS_DEF // Instruction cycle in ns
) (
   input wire logic clock, // System clock, 100 MHz
   input wire logic rstn, // Synchronous reset, active low
   input wire logic [15:0] addr, // Register address
   input wire logic [7:0] wdata, // Write data
   input wire logic wr, // Write strobe
   input wire logic rd, // Read strobe
   output logic [7:0] rdata, // Read data, cycle after rd
   input wire logic [11:0] sar_result, // Converter output bits
   output logic [10:0] source_select, // One-hot analog source
   output logic conv_run, // Converter running
   output logic eight_bit, // Converter in 8-bit mode
   output logic irq // Completion interrupt request
);

   // One unit is a third of an instruction cycle, rounded up to clocks
   localparam int unit_clks_raw = (tcyc_ns + 3 * `CLK_NS - 1) / (3 * `CLK_NS);
   localparam int unit_clks = (unit_clks_raw < 1) ? 1 : unit_clks_raw;

   sw_req_t req; // Bundled software request
   ctrl_reg_t ctrl_q, ctrl_d; // Control register
   mode_reg_t mode_q, mode_d; // Mode register
   low_reg_t low_q, low_d; // Low result and time code
   logic [7:0] high_q, high_d; // High result register
   logic [7:0] rdata_q, rdata_d; // Read data holding
   conv_state_t state_q, state_d; // Sequencer state
   logic dbl_q, dbl_d; // Next 12-bit run is doubled
   logic irq_q, irq_d; // Registered interrupt
   logic [10:0] sel_q, sel_d; // Registered source select
   logic [11:0] res_meta_q, res_sync_q; // Result synchroniser
   logic [2:0] time_code; // Division exponent
   logic [14:0] conv_units; // Length of the next conversion
   logic wr_ctrl, wr_mode, wr_low, wr_high; // Write decodes
   ctrl_reg_t wctrl; // Write data seen as control fields
   mode_reg_t wmode; // Write data seen as mode fields
   logic start, abort, done, busy; // Timer handshake

   assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
   assign wr_ctrl = req.wr && (req.addr == `ADDR_CTRL);
   assign wr_mode = req.wr && (req.addr == `ADDR_MODE);
   assign wr_low = req.wr && (req.addr == `ADDR_LOW);
   assign wr_high = req.wr && (req.addr == `ADDR_HIGH);
   // Field views keep bit positions out of the decode logic
   assign wctrl = ctrl_reg_t'(req.wdata);
   assign wmode = mode_reg_t'(req.wdata);

   // Start on a run write while idle; a run write while busy only continues
   assign start = wr_ctrl && wctrl.run_bit && (state_q == st_idle);
   // Clearing the run bit mid-conversion abandons it
   assign abort = wr_ctrl && !wctrl.run_bit && (state_q == st_conv);

   // Time code: low register bit 0 is the top bit
   assign time_code = {low_q.time_code_msb, mode_q.time_code_mid,
      mode_q.time_code_lsb};

   // Units = base * 2^n + 2, doubled when a 12-bit warm-up is due
   always_comb
   begin
      logic [14:0] base;
      base = 15'h0000;
      if (mode_q.resolution_select)
      begin
         base = (`UNITS_8 << time_code) + `UNITS_EXTRA;
         conv_units = base;
      end
      else
      begin
         base = (`UNITS_12 << time_code) + `UNITS_EXTRA;
         conv_units = dbl_q ? 15'(base << 1) : base;
      end
   end

   // Unit timer, one per block
   conv_timer #(
      .unit_clks(unit_clks)
   ) u_timer (
      .clock(clock),
      .rstn(rstn),
      .load(start),
      .abort(abort),
      .units(conv_units),
      .busy(busy),
      .done(done)
   );

   // Result bits arrive from the analog side, so two flops first
   always_ff @(posedge clock)
   begin
      res_meta_q <= sar_result;
      res_sync_q <= res_meta_q;
   end

   // Channel decode; prohibited codes select nothing
   always_comb
   begin
      sel_d = 11'h000;
      if (ctrl_q.channel_field <= `CH_LAST_LOW)
      begin
         sel_d[ctrl_q.channel_field] = 1'b1;
      end
      else if ((ctrl_q.channel_field >= `CH_FIRST_HIGH) &&
         (ctrl_q.channel_field <= `CH_LAST_HIGH))
      begin
         sel_d[4'(ctrl_q.channel_field - `CH_HIGH_OFFSET)] = 1'b1;
      end
      else if (ctrl_q.channel_field == `CH_REF)
      begin
         sel_d[`SEL_REF_BIT] = 1'b1;
      end
   end

   // Sequencer and control register next values
   always_comb
   begin
      state_d = state_q;
      ctrl_d = ctrl_q;
      if (wr_ctrl)
      begin
         // Software-held fields; flag may only be cleared
         ctrl_d.channel_field = wctrl.channel_field;
         ctrl_d.control_fixed_zero = wctrl.control_fixed_zero;
         ctrl_d.completion_irq_enable = wctrl.completion_irq_enable;
         if (!wctrl.completion_flag)
         begin
            ctrl_d.completion_flag = 1'b0;
         end
      end
      unique case (state_q)
         st_idle:
         begin
            if (start)
            begin
               state_d = st_conv;
            end
         end
         st_conv:
         begin
            if (done || abort)
            begin
               state_d = st_idle;
            end
         end
      endcase
      // Hardware set wins over a clear in the same cycle
      if (done)
      begin
         ctrl_d.completion_flag = 1'b1;
      end
      ctrl_d.run_bit = (state_d == st_conv);
   end

   // Mode, result and doubling next values
   always_comb
   begin
      mode_d = mode_q;
      low_d = low_q;
      high_d = high_q;
      dbl_d = dbl_q;
      if (wr_mode)
      begin
         mode_d = wmode;
         // Going from 8-bit back to 12-bit rearms the doubled run
         if (mode_q.resolution_select && !wmode.resolution_select)
         begin
            dbl_d = 1'b1;
         end
      end
      if (wr_low)
      begin
         low_d = low_reg_t'(wdata);
      end
      if (wr_high)
      begin
         high_d = wdata;
      end
      if (done)
      begin
         if (mode_q.resolution_select)
         begin
            high_d = res_sync_q[7:0];
         end
         else
         begin
            high_d = res_sync_q[11:4];
            low_d.result_nibble = res_sync_q[3:0];
            if (!wr_mode)
            begin
               dbl_d = 1'b0;
            end
         end
      end
   end

   // Read mux, answered one cycle after the strobe
   always_comb
   begin
      rdata_d = `REG_RESET;
      if (req.rd)
      begin
         unique case (req.addr)
            `ADDR_CTRL: rdata_d = ctrl_q;
            `ADDR_MODE: rdata_d = mode_q;
            `ADDR_LOW: rdata_d = low_q;
            `ADDR_HIGH: rdata_d = high_q;
            default: rdata_d = `REG_RESET;
         endcase
      end
   end

   // Interrupt follows flag and enable together
   assign irq_d = ctrl_q.completion_flag && ctrl_q.completion_irq_enable;

   // All state registers except the result synchroniser and the checking helpers; reset drops the run bit and idles the timer
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         state_q <= st_idle;
         ctrl_q <= ctrl_reg_t'(`REG_RESET);
         mode_q <= mode_reg_t'(`REG_RESET);
         low_q <= low_reg_t'(`REG_RESET);
         high_q <= `REG_RESET;
         rdata_q <= `REG_RESET;
         dbl_q <= 1'b1;
         irq_q <= 1'b0;
         sel_q <= 11'h000;
      end
      else
      begin
         state_q <= state_d;
         ctrl_q <= ctrl_d;
         mode_q <= mode_d;
         low_q <= low_d;
         high_q <= high_d;
         rdata_q <= rdata_d;
         dbl_q <= dbl_d;
         irq_q <= irq_d;
         sel_q <= sel_d;
      end
   end

   assign rdata = rdata_q;
   assign source_select = sel_q;
   assign conv_run = ctrl_q.run_bit;
   assign eight_bit = mode_q.resolution_select;
   assign irq = irq_q;

   // Checking helpers: expected clocks and clocks spent so far
   logic [31:0] exp_q, cnt_q;
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         exp_q <= 32'h0000_0000;
         cnt_q <= 32'h0000_0000;
      end
      else if (start)
      begin
         exp_q <= 32'(conv_units) * 32'(unit_clks);
         cnt_q <= 32'h0000_0000;
      end
      else if (busy)
      begin
         cnt_q <= cnt_q + 32'h0000_0001;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   sequence s_start;
      start;
   endsequence
   sequence s_running;
      busy && ctrl_q.run_bit;
   endsequence

   run_starts_a: assert property (s_start |=> s_running)
      else $error("run write did not start a conversion");
   done_drops_run_a: assert property (done |=> !ctrl_q.run_bit && !busy)
      else $error("run bit still set after completion");
   abort_stops_a: assert property (abort |=> !busy && !ctrl_q.run_bit)
      else $error("abort did not stop the conversion");
   flag_sets_a: assert property (done |=> ctrl_q.completion_flag)
      else $error("completion flag not set");
   irq_follows_a: assert property (ctrl_q.completion_flag
      && ctrl_q.completion_irq_enable |=> irq)
      else $error("interrupt missing with flag and enable set");
   irq_quiet_a: assert property (!ctrl_q.completion_flag
      || !ctrl_q.completion_irq_enable |=> !irq)
      else $error("interrupt raised without flag and enable");
   flag_holds_a: assert property (ctrl_q.completion_flag
      && !(wr_ctrl && !wctrl.completion_flag) |=> ctrl_q.completion_flag)
      else $error("completion flag lost without a clear");
   low_kept_a: assert property (done && mode_q.resolution_select && !wr_low
      |=> $stable(low_q) && high_q == $past(res_sync_q[7:0]))
      else $error("8-bit completion disturbed the low register");
   split_12_a: assert property (done && !mode_q.resolution_select && !wr_high
      |=> high_q == $past(res_sync_q[11:4])
      && low_q.result_nibble == $past(res_sync_q[3:0]))
      else $error("12-bit result placed wrongly");
   length_exact_a: assert property (done |-> (cnt_q + 32'h0000_0001) == exp_q)
      else $error("conversion length wrong");
   ref_select_a: assert property (ctrl_q.channel_field == `CH_REF
      |=> source_select[`SEL_REF_BIT])
      else $error("reference source not selected");

endmodule

// ---- tb/sar_adc_sequencer_tb.sv ----
`timescale 1ns/100ps
`include "sar_adc_params.svh"

module sar_adc_sequencer_tb;
   import sar_adc_pkg::*;
   logic clock; // System clock
   logic rstn; // Reset, active low
   logic [15:0] addr; // Register address
   logic [7:0] wdata; // Write data
   logic wr; // Write strobe
   logic rd; // Read strobe
   logic [7:0] rdata; // Read data
   logic [11:0] sar_result; // Converter bits
   logic [10:0] source_select; // One-hot source
   logic conv_run; // Converter running
   logic eight_bit; // 8-bit mode
   logic irq; // Interrupt request
   int error_cnt = 0; // Mismatches
   int comparisons = 0; // Checks made
   int cycles = 0; // Clocks for the hang guard
   logic [7:0] got; // Last read value
   logic [3:0] codes [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hE};

   sar_adc_sequencer #(.tcyc_ns(30)) dut (.clock(clock), .rstn(rstn), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sar_result(sar_result),
      .source_select(source_select), .conv_run(conv_run), .eight_bit(eight_bit), .irq(irq));
   sar_model far (.clock(clock), .rstn(rstn), .conv_run(conv_run),
      .source_select(source_select), .sar_result(sar_result));

   // 100 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Hang guard; the whole run needs well under this
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         error_cnt++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One-cycle write strobe
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask

   // Read data is valid only in the cycle after the strobe
   task automatic rd_reg(input logic [15:0] a);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      got = rdata;
   endtask

   task automatic settle();
      @(posedge clock);
      #1;
   endtask

   // Program mode and time code, then check the resolution output
   task automatic setup(input logic [7:0] mode, input logic [7:0] low);
      wr_reg(`ADDR_MODE, mode);
      wr_reg(`ADDR_LOW, low);
      settle();
      chk("eight_bit", {15'h0000, mode[6]}, {15'h0000, eight_bit});
   endtask

   // Full conversion in the documented software order
   task automatic run_case(input logic [7:0] mode, input logic [7:0] low, input logic [7:0] ctrl,
      input int len, input logic [7:0] hi, input logic [7:0] lo, input string name);
      int cnt;
      cnt = 0;
      setup(mode, low);
      wr_reg(`ADDR_CTRL, ctrl);
      // Sample the cycle launched by the start edge too, so every run cycle counts
      #1;
      for (int i = 0; i < 8000; i++)
      begin
         if (conv_run === 1'b1)
            cnt++;
         else if (cnt > 0)
            break;
         settle();
      end
      chk("length", len[15:0], cnt[15:0]);
      rd_reg(`ADDR_CTRL);
      chk("ctrl done", {8'h00, ctrl[7:3], 3'b010 | {2'b00, ctrl[0]}}, {8'h00, got});
      chk("irq set", {15'h0000, ctrl[0]}, {15'h0000, irq});
      repeat (10) @(posedge clock);
      rd_reg(`ADDR_CTRL);
      chk("flag held", {15'h0000, 1'b1}, {15'h0000, got[1]});
      wr_reg(`ADDR_CTRL, {ctrl[7:3], 2'b00, ctrl[0]});
      repeat (2) settle();
      chk("irq clear", 16'h0000, {15'h0000, irq});
      rd_reg(`ADDR_HIGH);
      chk("high", {8'h00, hi}, {8'h00, got});
      rd_reg(`ADDR_LOW);
      chk("low", {8'h00, lo}, {8'h00, got});
      $display("test %s done", name);
   endtask

   initial
   begin
      rstn = 1'b0;
      addr = 16'h0000;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      repeat (4) @(posedge clock);
      rstn <= 1'b1;
      // Reset values and an unmapped address
      for (int i = 0; i < 5; i++)
      begin
         rd_reg(`ADDR_CTRL + i[15:0]);
         chk("reset reg", 16'h0000, {8'h00, got});
      end
      chk("reset source", 16'h0001, {5'h00, source_select});
      chk("reset run irq", 16'h0000, {14'h0000, conv_run, irq});
      $display("test reset done");
      // Every legal channel code
      for (int i = 0; i < 11; i++)
      begin
         wr_reg(`ADDR_CTRL, {codes[i], 4'h0});
         settle();
         chk("source", 16'(11'h001 << i), {5'h00, source_select});
         rd_reg(`ADDR_CTRL);
         chk("ctrl back", {8'h00, codes[i], 4'h0}, {8'h00, got});
      end
      $display("test channels done");
      run_case(8'h00, 8'h00, 8'h55, 108, 8'hA5, 8'h50, "first12");
      run_case(8'h01, 8'h00, 8'hE4, 106, 8'hA5, 8'hA0, "second12");
      run_case(8'h40, 8'hA0, 8'h85, 34, 8'h57, 8'hA0, "eight");
      run_case(8'h43, 8'h01, 8'h05, 4098, 8'h50, 8'h01, "eight_slow");
      run_case(8'h00, 8'h00, 8'hA5, 108, 8'hA5, 8'h90, "back12");
      // Abort mid-conversion: stops, no flag, high result kept
      setup(8'h03, 8'h01);
      wr_reg(`ADDR_CTRL, 8'h04);
      repeat (30) settle();
      chk("running", 16'h0001, {15'h0000, conv_run});
      wr_reg(`ADDR_CTRL, 8'h00);
      settle();
      chk("aborted", 16'h0000, {15'h0000, conv_run});
      repeat (60) @(posedge clock);
      rd_reg(`ADDR_CTRL);
      chk("no flag", 16'h0000, {8'h00, got});
      rd_reg(`ADDR_HIGH);
      chk("high kept", 16'h00A5, {8'h00, got});
      $display("test abort done");
      // Reset mid-conversion, then doubling again
      wr_reg(`ADDR_CTRL, 8'h04);
      repeat (10) @(posedge clock);
      rstn <= 1'b0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      settle();
      chk("reset run", 16'h0000, {15'h0000, conv_run});
      rd_reg(`ADDR_CTRL);
      chk("reset ctrl", 16'h0000, {8'h00, got});
      run_case(8'h00, 8'h00, 8'h55, 108, 8'hA5, 8'h50, "after_reset");
      print_verdict();
   end
endmodule

// ---- tb/sar_model.sv ----
`timescale 1ns/100ps

// Stand-in for the analog core; the result names the routed source
module sar_model (
   input wire logic clock, // System clock
   input wire logic rstn, // Reset, active low
   input wire logic conv_run, // Converter running
   input wire logic [10:0] source_select, // One-hot source
   output logic [11:0] sar_result // Result bits
);
   logic [3:0] idx; // Index of the routed source

   // Decode the one-hot select back to an index
   always_comb
   begin
      idx = 4'hF;
      for (int i = 0; i < 11; i++)
         if (source_select[i])
            idx = i[3:0];
   end

   // Settled only while running; bits churn when idle so a late capture shows
   always_ff @(posedge clock)
      if (!rstn)
         sar_result <= 12'h000;
      else if (conv_run)
         sar_result <= {8'hA5, idx};
      else
         sar_result <= ~sar_result;
endmodule
